//--- kg_key_guard_cfg.svh
`ifndef KG_KEY_GUARD_CFG_SVH
`define KG_KEY_GUARD_CFG_SVH

// Geometry of the protected region
`define KG_SLOTS 128
`define KG_MEM_WORDS 1024
`define KG_OTP_WORDS 10'h040
`define KG_EPROT_IDX 10'h040
`define KG_HDR_BASE 10'h080
`define KG_HDR_END 10'h180
`define KG_VAL_BASE 10'h180
`define KG_VAL_END 10'h380
`define KG_HDR_RANGE_BYTES 12'h400

// Header permission word fields
`define KG_PERM_WRITE 0
`define KG_PERM_READ 1
`define KG_PERM_PUSH 2
`define KG_PERM_ACTIVE 3

// Fixed words
`define KG_ERROR_WORD 32'hdeaddead
`define KG_ERASED_WORD 32'hffffffff
`define KG_ERASED_HALF 16'hffff
`define KG_ERASE_PROTECT_KEY 32'h5a5ac3c3

// Guard register offsets
`define KG_REG_PUSH 8'h00
`define KG_REG_SELECT 8'h04
`define KG_REG_STATUS 8'h08
`define KG_REG_ERASE_CTL 8'h0c
`define KG_REG_ERASE_STAT 8'h10

// Status fields
`define KG_STAT_SELECTED 0
`define KG_STAT_BLOCKED 1

// Reset value and limits
`define KG_SELECT_RESET 8'h00
`define KG_MAX_SLOT_ID 8'h80
`define KG_PUSH_BEATS 2'h3

`endif

//--- kg_key_guard_pkg.sv
`include "kg_key_guard_cfg.svh"

package kg_key_guard_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        KG_ST_IDLE,
        KG_ST_PUSH,
        KG_ST_ERASE
    } kg_state_type;

    // CPU access into the protected region
    typedef struct packed {
        logic read;
        logic write;
        logic secure;
        logic [11:0] addr;
        logic [31:0] wdata;
    } kg_mem_req_type;

    // Key push beat toward a secure destination
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } kg_push_type;

endpackage : kg_key_guard_pkg

//--- kg_key_guard.sv
`timescale 1ns/100ps
`include "kg_key_guard_cfg.svh"

// Notes on behaviour
// - 128 slots, 128-bit value, policy, destination
// - Long keys span several slots
// - Push selected value to its destination
// - Only secure accesses are accepted
// - Non-secure transactions are always blocked
// - OTP halfwords programmable only once
// - Headers occupy a 0x400 byte range
// - Per-access allow/block by security, type
// - Header, OTP and protect word reads free, others restricted
// - Restricted access needs matching slot selection
// - Illegal reads return fixed error word
// - One selected slot, its own permissions
// - OTP and key storage checked separately
// - Protection blocks whole-flash erase requests
// - Key word enables permanent erase protection
// - Boot code may re-enable debug erase
// - Slot ids 1..128, zero means none
// - Illegal key slot access sets blocked
// - OTP word write, unset halfword all ones
module kg_key_guard
    import kg_key_guard_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Guard register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic i_reg_secure,
    output logic [31:0] o_reg_rdata,
    // Protected region access
    input wire kg_mem_req_type i_mem,
    output logic [31:0] o_mem_rdata,
    // Whole-flash erase requests
    input wire logic i_flash_ctrl_erase_all_request,
    input wire logic i_debug_erase_all_request,
    // Key push channel
    output kg_push_type o_push,
    // Status
    output logic o_blocked,
    output logic o_erase_busy
);

    // Region storage: OTP, protect word, headers, values
    logic [31:0] mem [0:`KG_MEM_WORDS-1];

    kg_state_type state; // Sequencer state
    logic [7:0] slot_select; // Selected slot id, zero is none
    logic stat_selected; // Sticky selected flag
    logic stat_blocked; // Sticky blocked flag
    logic erase_reenable; // Debug erase allowed despite protection
    logic [9:0] erase_idx; // Erase walk position
    logic [1:0] push_beat; // Push word counter
    logic [6:0] push_slot; // Slot being pushed, latched at start

    // Decode of the region access
    logic [9:0] idx;
    logic [9:0] hdr_off;
    logic [9:0] val_off;
    logic [7:0] acc_id;
    logic is_otp;
    logic is_ep;
    logic is_hdr;
    logic is_val;
    logic [31:0] old_word;
    logic [31:0] acc_perm;
    logic hit;
    logic busy;
    logic otp_ok;
    logic wr_ok;
    logic rd_ok;
    logic mem_wr;
    logic mem_blk;
    logic reg_blk;
    logic push_req;
    logic push_ok;
    logic [6:0] sel_slot;
    logic [31:0] sel_perm;
    logic [31:0] sel_dest;
    logic protected_now;
    logic erase_go;
    logic select_wr;
    logic sel_bad;

    // Slot index under selection; zero selection is masked by hit checks
    assign sel_slot = 7'(slot_select - 8'h01);
    assign sel_dest = mem[`KG_HDR_BASE + {2'h0, sel_slot, 1'b0}];
    assign sel_perm = mem[`KG_HDR_BASE + {2'h0, sel_slot, 1'b1}];
    assign busy = (state != KG_ST_IDLE);

    // Word index and region classification
    always_comb
    begin
        idx = i_mem.addr[11:2];
        hdr_off = idx - `KG_HDR_BASE;
        val_off = idx - `KG_VAL_BASE;
        is_otp = (idx < `KG_OTP_WORDS);
        is_ep = (idx == `KG_EPROT_IDX);
        // Two header words per slot over a 0x400 byte range
        is_hdr = (idx >= `KG_HDR_BASE) && (idx < `KG_HDR_END);
        is_val = (idx >= `KG_VAL_BASE) && (idx < `KG_VAL_END);
        if (is_hdr)
        begin
            acc_id = {1'b0, hdr_off[7:1]} + 8'h01;
        end
        else
        begin
            acc_id = {1'b0, val_off[8:2]} + 8'h01;
        end
    end

    // Access verdict
    always_comb
    begin
        old_word = mem[idx];
        acc_perm = sel_perm;
        // Only the selected slot opens its registers
        hit = (slot_select != `KG_SELECT_RESET) && (acc_id == slot_select);
        // Each halfword: either still erased or masked as all ones
        otp_ok = ((old_word[31:16] == `KG_ERASED_HALF) ||
                  (i_mem.wdata[31:16] == `KG_ERASED_HALF)) &&
                 ((old_word[15:0] == `KG_ERASED_HALF) ||
                  (i_mem.wdata[15:0] == `KG_ERASED_HALF));
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        // Non-secure traffic never passes, whatever the guard's own attribute
        if (i_mem.secure && !busy)
        begin
            if (is_otp)
            begin
                // OTP has its own rule set, independent of slots
                wr_ok = otp_ok;
                rd_ok = 1'b1;
            end
            else if (is_ep)
            begin
                wr_ok = (old_word == `KG_ERASED_WORD);
                rd_ok = 1'b1;
            end
            else if (is_hdr)
            begin
                // Header reads are free, writes restricted
                wr_ok = hit && acc_perm[`KG_PERM_ACTIVE] && acc_perm[`KG_PERM_WRITE] &&
                        (old_word == `KG_ERASED_WORD);
                rd_ok = 1'b1;
            end
            else if (is_val)
            begin
                wr_ok = hit && acc_perm[`KG_PERM_ACTIVE] && acc_perm[`KG_PERM_WRITE] &&
                        (old_word == `KG_ERASED_WORD);
                rd_ok = hit && acc_perm[`KG_PERM_ACTIVE] && acc_perm[`KG_PERM_READ];
            end
            else
            begin
                wr_ok = 1'b0;
                rd_ok = 1'b0;
            end
        end
        mem_wr = i_mem.write && wr_ok;
        mem_blk = (i_mem.write && !wr_ok) || (i_mem.read && !rd_ok);
    end

    // Guard register side decisions
    assign select_wr = i_reg_write && i_reg_secure && (i_reg_addr == `KG_REG_SELECT);
    assign sel_bad = select_wr && (i_reg_wdata[31:0] > {24'h0, `KG_MAX_SLOT_ID});
    assign push_req = i_reg_write && i_reg_secure && (i_reg_addr == `KG_REG_PUSH) &&
                      i_reg_wdata[0];
    // Push needs an active, pushable slot with a programmed destination
    assign push_ok = !busy && (slot_select != `KG_SELECT_RESET) &&
                     sel_perm[`KG_PERM_ACTIVE] && sel_perm[`KG_PERM_PUSH] &&
                     (sel_dest != `KG_ERASED_WORD);
    assign reg_blk = ((i_reg_write || i_reg_read) && !i_reg_secure) || sel_bad ||
                     (push_req && !push_ok);

    // Protection word programmed: flash-controller erase stays off, debug erase only when re-enabled
    // Decided by an if so a never-erased, unknown word counts as unprotected
    always_comb
    begin
        protected_now = 1'b0;
        if (mem[`KG_EPROT_IDX] == `KG_ERASE_PROTECT_KEY)
        begin
            protected_now = 1'b1;
        end
    end
    // Internal requests always refused under protection; debug only when re-enabled
    assign erase_go = !busy && (i_flash_ctrl_erase_all_request || i_debug_erase_all_request) &&
                      (!protected_now ||
                       (i_debug_erase_all_request && erase_reenable));

    // Storage updates: programming only clears bits, erase sets words to ones
    always_ff @(posedge i_core_clk)
    begin
        if (state == KG_ST_ERASE)
        begin
            mem[erase_idx] <= `KG_ERASED_WORD;
        end
        else if (mem_wr)
        begin
            // Refused writes fall through and leave contents alone
            mem[idx] <= old_word & i_mem.wdata;
        end
    end

    // Sequencer: idle, key push, whole erase
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state <= KG_ST_IDLE;
            erase_idx <= 10'h000;
            push_beat <= 2'h0;
            push_slot <= 7'h00;
        end
        else
        begin
            case (state)
                KG_ST_IDLE:
                begin
                    if (erase_go)
                    begin
                        state <= KG_ST_ERASE;
                        erase_idx <= 10'h000;
                    end
                    else if (push_req && push_ok)
                    begin
                        state <= KG_ST_PUSH;
                        push_beat <= 2'h0;
                        push_slot <= sel_slot;
                    end
                end
                KG_ST_PUSH:
                begin
                    // Four beats carry the 128-bit value
                    push_beat <= push_beat + 2'h1;
                    if (push_beat == `KG_PUSH_BEATS)
                    begin
                        state <= KG_ST_IDLE;
                    end
                end
                KG_ST_ERASE:
                begin
                    erase_idx <= erase_idx + 10'h001;
                    if (erase_idx == 10'(`KG_MEM_WORDS - 1))
                    begin
                        state <= KG_ST_IDLE;
                    end
                end
                default:
                begin
                    state <= KG_ST_IDLE;
                end
            endcase
        end
    end

    // Push channel; the value reaches a CPU read only through a selected slot with read permission
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_push <= '0;
        end
        else if (state == KG_ST_PUSH)
        begin
            o_push.valid <= 1'b1;
            // Each beat lands one word further on
            o_push.addr <= mem[`KG_HDR_BASE + {2'h0, push_slot, 1'b0}] +
                           {28'h0, push_beat, 2'h0};
            o_push.data <= mem[`KG_VAL_BASE + {1'b0, push_slot, push_beat}];
        end
        else
        begin
            o_push <= '0;
        end
    end

    // Slot selection; out-of-range ids are ignored
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            slot_select <= `KG_SELECT_RESET;
        end
        else if (select_wr && !sel_bad)
        begin
            slot_select <= i_reg_wdata[7:0];
        end
    end

    // Temporary debug erase permission, consumed by the erase it allows
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            erase_reenable <= 1'b0;
        end
        else if (erase_go && i_debug_erase_all_request)
        begin
            erase_reenable <= 1'b0;
        end
        else if (i_reg_write && i_reg_secure && (i_reg_addr == `KG_REG_ERASE_CTL))
        begin
            erase_reenable <= i_reg_wdata[0];
        end
    end

    // Sticky status; a new event beats a write-one clear in the same cycle
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            stat_selected <= 1'b0;
            stat_blocked <= 1'b0;
        end
        else
        begin
            if ((i_mem.read || i_mem.write) && !mem_blk && hit && (is_hdr || is_val))
            begin
                stat_selected <= 1'b1;
            end
            else if (i_reg_write && i_reg_secure && (i_reg_addr == `KG_REG_STATUS) &&
                     i_reg_wdata[`KG_STAT_SELECTED])
            begin
                stat_selected <= 1'b0;
            end
            if (mem_blk || reg_blk)
            begin
                stat_blocked <= 1'b1;
            end
            else if (i_reg_write && i_reg_secure && (i_reg_addr == `KG_REG_STATUS) &&
                     i_reg_wdata[`KG_STAT_BLOCKED])
            begin
                stat_blocked <= 1'b0;
            end
        end
    end

    // Region read data, one cycle after the strobe
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_mem_rdata <= 32'h00000000;
        end
        else if (i_mem.read)
        begin
            // Illegal reads see only the error word
            o_mem_rdata <= rd_ok ? old_word : `KG_ERROR_WORD;
        end
    end

    // Guard register read data
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 32'h00000000;
        end
        else if (i_reg_read)
        begin
            if (!i_reg_secure)
            begin
                o_reg_rdata <= `KG_ERROR_WORD;
            end
            else
            begin
                case (i_reg_addr)
                    `KG_REG_SELECT: o_reg_rdata <= {24'h0, slot_select};
                    `KG_REG_STATUS: o_reg_rdata <= {30'h0, stat_blocked, stat_selected};
                    `KG_REG_ERASE_CTL: o_reg_rdata <= {31'h0, erase_reenable};
                    `KG_REG_ERASE_STAT: o_reg_rdata <= {30'h0, busy, protected_now};
                    default: o_reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Flag outputs from flops
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_blocked <= 1'b0;
            o_erase_busy <= 1'b0;
        end
        else
        begin
            o_blocked <= stat_blocked;
            o_erase_busy <= (state == KG_ST_ERASE);
        end
    end

endmodule : kg_key_guard

//--- kg_key_guard_monitor.sv
`timescale 1ns/100ps
`include "kg_key_guard_cfg.svh"

// Port-level watcher for the key guard
module kg_key_guard_monitor
    import kg_key_guard_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic i_reg_secure,
    input wire logic [31:0] o_reg_rdata,
    // Region port
    input wire kg_mem_req_type i_mem,
    input wire logic [31:0] o_mem_rdata,
    // Erase, push and status
    input wire logic i_flash_ctrl_erase_all_request,
    input wire logic i_debug_erase_all_request,
    input wire kg_push_type o_push,
    input wire logic o_blocked,
    input wire logic o_erase_busy
);
    // Busy cycles of the running erase walk
    logic [10:0] busy_len;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // Count busy cycles; cleared whenever the walk is not running
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || !o_erase_busy)
            busy_len <= 11'h000;
        else
            busy_len <= busy_len + 11'h001;
    end

    // A push is four beats and then a gap
    sequence s_four_beats;
        o_push.valid [*4] ##1 !o_push.valid;
    endsequence

    // Any non-secure region access
    sequence s_ns_access;
        (i_mem.read || i_mem.write) && !i_mem.secure;
    endsequence

    a_ns_read_error:
        assert property (i_mem.read && !i_mem.secure |=> o_mem_rdata == `KG_ERROR_WORD)
        else $error("non-secure region read not answered with error word");
    a_ns_sets_blocked:
        assert property (s_ns_access |-> ##2 o_blocked)
        else $error("non-secure region access did not raise blocked");
    a_reg_ns_error:
        assert property (i_reg_read && !i_reg_secure |=> o_reg_rdata == `KG_ERROR_WORD)
        else $error("non-secure register read not answered with error word");
    a_reg_ns_blocked:
        assert property ((i_reg_read || i_reg_write) && !i_reg_secure |-> ##2 o_blocked)
        else $error("non-secure register access did not raise blocked");
    a_push_burst:
        assert property ($rose(o_push.valid) |-> s_four_beats)
        else $error("push burst is not four beats long");
    a_push_addr_step:
        assert property (o_push.valid && $past(o_push.valid)
            |-> o_push.addr == $past(o_push.addr) + 32'h4)
        else $error("push beat address did not advance by one word");
    a_push_not_erasing:
        assert property (o_erase_busy |-> !o_push.valid)
        else $error("push beat seen during erase walk");
    a_erase_span:
        assert property ($fell(o_erase_busy) |-> busy_len == 11'h400)
        else $error("erase walk length is not one full region");
    a_blocked_clear_cause:
        assert property ($fell(o_blocked) |-> $past(i_reg_write && i_reg_secure
            && i_reg_addr == `KG_REG_STATUS && i_reg_wdata[1], 2))
        else $error("blocked dropped without a clear write");
endmodule : kg_key_guard_monitor

//--- kg_push_sink.sv
`timescale 1ns/100ps

// Secure key destination: gathers pushed beats like a write-only key register
module kg_push_sink
    import kg_key_guard_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Push channel from the guard
    input wire kg_push_type i_push,
    // Captured results
    output logic [127:0] o_key,
    output logic [31:0] o_dest,
    output logic [2:0] o_beats,
    output logic o_addr_err
);
    // Beats shift in from the top so word 0 ends up lowest
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_key <= 128'h0;
            o_dest <= 32'h0;
            o_beats <= 3'h0;
            o_addr_err <= 1'b0;
        end
        else if (i_push.valid)
        begin
            if (o_beats == 3'h0)
                o_dest <= i_push.addr;
            else if (i_push.addr != o_dest + {27'h0, o_beats, 2'h0})
                o_addr_err <= 1'b1;
            o_key <= {i_push.data, o_key[127:32]};
            o_beats <= o_beats + 3'h1;
        end
    end
endmodule : kg_push_sink

//--- kg_key_guard_tb.sv
`timescale 1ns/100ps
`include "kg_key_guard_cfg.svh"

module kg_key_guard_tb
    import kg_key_guard_pkg::*;
;
    // Design ports
    logic i_core_clk, i_rst, i_reg_write, i_reg_read, i_reg_secure;
    logic [7:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, o_mem_rdata;
    kg_mem_req_type i_mem;
    logic i_flash_ctrl_erase_all_request, i_debug_erase_all_request;
    kg_push_type o_push;
    logic o_blocked, o_erase_busy;
    // Sink results and bench state
    logic [127:0] sink_key;
    logic [31:0] sink_dest, rd;
    logic [2:0] sink_beats;
    logic sink_addr_err;
    logic [31:0] key [4] = '{32'h0123cafe, 32'h4567beef, 32'h89abf00d, 32'hcdef1357};
    int err_total, total_checks;

    kg_key_guard i_kg_key_guard (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wdata,
        .i_reg_write, .i_reg_read, .i_reg_secure, .o_reg_rdata, .i_mem, .o_mem_rdata,
        .i_flash_ctrl_erase_all_request, .i_debug_erase_all_request, .o_push,
        .o_blocked, .o_erase_busy);
    kg_push_sink i_kg_push_sink (.i_core_clk, .i_rst, .i_push(o_push), .o_key(sink_key),
        .o_dest(sink_dest), .o_beats(sink_beats), .o_addr_err(sink_addr_err));

    // 100 MHz clock
    initial
    begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] e);
        total_checks++;
        if (seen !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, e, seen);
        end
    endtask : check

    // One register cycle; read data is taken in the answer cycle
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic sec);
        @(posedge i_core_clk);
        i_reg_write <= wr;
        i_reg_read <= !wr;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_secure <= sec;
        @(posedge i_core_clk);
        i_reg_write <= 1'b0;
        i_reg_read <= 1'b0;
        #1 rd = o_reg_rdata;
    endtask : reg_acc

    // One region cycle, same shape as the register cycle
    task automatic mem_acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic sec);
        @(posedge i_core_clk);
        i_mem <= '{read: !wr, write: wr, secure: sec, addr: a, wdata: d};
        @(posedge i_core_clk);
        i_mem.read <= 1'b0;
        i_mem.write <= 1'b0;
        #1 rd = o_mem_rdata;
    endtask : mem_acc

    task automatic reg_rd_chk(input logic [7:0] a, input logic sec, input logic [31:0] e);
        reg_acc(1'b0, a, 32'h0, sec);
        check($sformatf("reg %h", a), rd, e);
    endtask : reg_rd_chk

    task automatic mem_rd_chk(input logic [11:0] a, input logic sec, input logic [31:0] e);
        mem_acc(1'b0, a, 32'h0, sec);
        check($sformatf("mem %h", a), rd, e);
    endtask : mem_rd_chk

    // Blocked flag lags the status bit by a cycle; clear it after looking
    task automatic blk_chk(input logic e);
        repeat (2) @(posedge i_core_clk);
        #1 check("blocked", {31'h0, o_blocked}, {31'h0, e});
        reg_acc(1'b1, `KG_REG_STATUS, 32'h2, 1'b1);
    endtask : blk_chk

    // Erase pulse; checks whether the walk starts, then waits it out
    task automatic erase_req(input logic dbg, input logic run);
        @(posedge i_core_clk);
        i_flash_ctrl_erase_all_request <= !dbg;
        i_debug_erase_all_request <= dbg;
        @(posedge i_core_clk);
        i_flash_ctrl_erase_all_request <= 1'b0;
        i_debug_erase_all_request <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        #1 check("erase busy", {31'h0, o_erase_busy}, {31'h0, run});
        for (int n = 0; n < 1100 && o_erase_busy; n++)
            @(posedge i_core_clk);
        #1;
    endtask : erase_req

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Two erase walks plus about 130 cycles of traffic
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        err_total++;
        results();
    end

    // Main sequence
    initial
    begin
        {i_reg_write, i_reg_read, i_reg_secure, i_reg_addr, i_reg_wdata} = '0;
        {i_flash_ctrl_erase_all_request, i_debug_erase_all_request} = 2'h0;
        i_mem = '0;
        i_rst = 1'b1;
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        erase_req(1'b0, 1'b1);
        reg_rd_chk(`KG_REG_SELECT, 1'b1, 32'h0);
        reg_rd_chk(8'h40, 1'b1, 32'h0);
        reg_rd_chk(`KG_REG_SELECT, 1'b0, `KG_ERROR_WORD);
        blk_chk(1'b1);
        mem_rd_chk(12'h204, 1'b1, `KG_ERASED_WORD);
        mem_rd_chk(12'h600, 1'b1, `KG_ERROR_WORD);
        blk_chk(1'b1);
        reg_acc(1'b1, `KG_REG_SELECT, 32'h81, 1'b1);
        reg_rd_chk(`KG_REG_SELECT, 1'b1, 32'h0);
        blk_chk(1'b1);
        reg_acc(1'b1, `KG_REG_SELECT, 32'h1, 1'b1);
        reg_acc(1'b1, `KG_REG_SELECT, 32'h5, 1'b0);
        reg_rd_chk(`KG_REG_SELECT, 1'b1, 32'h1);
        blk_chk(1'b1);
        mem_acc(1'b1, 12'h200, 32'h00001000, 1'b1);
        for (int k = 0; k < 4; k++)
            mem_acc(1'b1, 12'h600 + 12'(4 * k), key[k], 1'b1);
        mem_acc(1'b1, 12'h204, 32'hfffffffe, 1'b1);
        blk_chk(1'b0);
        reg_rd_chk(`KG_REG_STATUS, 1'b1, 32'h1);
        mem_rd_chk(12'h604, 1'b1, key[1]);
        mem_acc(1'b1, 12'h600, 32'h0, 1'b1);
        mem_rd_chk(12'h600, 1'b1, key[0]);
        mem_rd_chk(12'h610, 1'b1, `KG_ERROR_WORD);
        mem_rd_chk(12'h604, 1'b0, `KG_ERROR_WORD);
        blk_chk(1'b1);
        reg_acc(1'b1, `KG_REG_PUSH, 32'h1, 1'b1);
        repeat (8) @(posedge i_core_clk);
        #1;
        for (int k = 0; k < 4; k++)
            check("pushed word", sink_key[32 * k +: 32], key[k]);
        check("push dest", sink_dest, 32'h00001000);
        check("push beats", {29'h0, sink_beats}, 32'h4);
        check("push addr", {31'h0, sink_addr_err}, 32'h0);
        mem_acc(1'b1, 12'h000, 32'hffffaabb, 1'b1);
        mem_acc(1'b1, 12'h000, 32'h1234ffff, 1'b1);
        mem_rd_chk(12'h000, 1'b1, 32'h1234aabb);
        blk_chk(1'b0);
        mem_acc(1'b1, 12'h000, 32'h5678ffff, 1'b1);
        mem_rd_chk(12'h000, 1'b1, 32'h1234aabb);
        blk_chk(1'b1);
        mem_acc(1'b1, 12'h100, `KG_ERASE_PROTECT_KEY, 1'b1);
        reg_rd_chk(`KG_REG_ERASE_STAT, 1'b1, 32'h1);
        erase_req(1'b0, 1'b0);
        erase_req(1'b1, 1'b0);
        mem_rd_chk(12'h000, 1'b1, 32'h1234aabb);
        reg_acc(1'b1, `KG_REG_ERASE_CTL, 32'h1, 1'b1);
        erase_req(1'b1, 1'b1);
        mem_rd_chk(12'h000, 1'b1, `KG_ERASED_WORD);
        results();
    end
endmodule : kg_key_guard_tb

bind kg_key_guard kg_key_guard_monitor i_kg_key_guard_monitor (.i_core_clk, .i_rst,
    .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read, .i_reg_secure, .o_reg_rdata,
    .i_mem, .o_mem_rdata, .i_flash_ctrl_erase_all_request, .i_debug_erase_all_request,
    .o_push, .o_blocked, .o_erase_busy);
